// File: testbench/clkout_consumer.sv
// board clock consumers: count rising edges seen on the three pins
// assumes pins pulled low on the board while released
`timescale 1ns/1ps
`default_nettype none
module clkout_consumer (
  // pins, order five, three, two
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  // counting window
  input wire logic count_clear,
  output int edge_two,
  output int edge_three,
  output int edge_five
);
  tri0 [2:0] line;
  // a released pin floats to the pull-down, never to its last value
  assign line[0] = pin_oe[0] ? pin_out[0] : 1'bz;
  assign line[1] = pin_oe[1] ? pin_out[1] : 1'bz;
  assign line[2] = pin_oe[2] ? pin_out[2] : 1'bz;
  always @(posedge line[2] or posedge count_clear) begin
    edge_two <= count_clear ? 0 : edge_two + 1;
  end
  always @(posedge line[1] or posedge count_clear) begin
    edge_three <= count_clear ? 0 : edge_three + 1;
  end
  always @(posedge line[0] or posedge count_clear) begin
    edge_five <= count_clear ? 0 : edge_five + 1;
  end
endmodule
`default_nettype wire

// File: testbench/clkout_control_assertions.sv
// checker for the clock output pin control block
// assumes it is bound to clkout_control and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module clkout_control_assertions
  import clkout_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // pins
  input wire logic pin_two_out,
  input wire logic pin_two_oe,
  input wire logic pin_three_out,
  input wire logic pin_three_oe,
  input wire logic pin_five_out,
  input wire logic pin_five_oe
);
  // override as last written, to know which fields are forced
  logic ovr_r;
  logic ovr_nxt;
  always_comb begin
    ovr_nxt = ovr_r;
    if (wr && addr == override_offset) begin
      ovr_nxt = wdata[override_bit];
    end
  end
  always_ff @(posedge clk) begin
    ovr_r <= resetn ? ovr_nxt : 1'b0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0)
    else $error("read data not zero outside read cycle");
  chk_three_sel_held: assert property (
    rd && addr == source_select_offset && !ovr_r |=> rdata[4:3] == three_sel_fll)
    else $error("pin three select not held at loop code");
  chk_two_halve_forced: assert property (
    rd && addr == divide_control_offset && !ovr_r |=> rdata[pin_two_halve_bit])
    else $error("pin two halve not forced");
  chk_five_halve_forced: assert property (
    rd && addr == divide_control_offset && !ovr_r |=> rdata[pin_five_halve_bit])
    else $error("pin five halve not forced");
  chk_override_read: assert property (
    rd && addr == override_offset |=> rdata[0] == $past(ovr_r))
    else $error("override read back wrong");
  chk_unmapped_zero: assert property (
    rd && (addr < source_select_offset || addr > override_offset) |=> rdata == 16'h0)
    else $error("unmapped read not zero");
  chk_two_quiet: assert property (!pin_two_oe |-> !pin_two_out)
    else $error("pin two carries data while released");
  chk_three_quiet: assert property (!pin_three_oe |-> !pin_three_out)
    else $error("pin three carries data while released");
  chk_five_quiet: assert property (!pin_five_oe |-> !pin_five_out)
    else $error("pin five carries data while released");
  chk_enable_off: assert property (
    wr && addr == pin_enable_offset && !wdata[pin_two_enable_bit] |-> ##[1:3] !pin_two_oe)
    else $error("pin two not released");
  chk_enable_on: assert property (
    wr && addr == pin_enable_offset && wdata[pin_three_enable_bit] |-> ##[1:3] pin_three_oe)
    else $error("pin three not driven");
endmodule
bind clkout_control clkout_control_assertions chk (.clk(clk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pin_two_out(pin_two_out), .pin_two_oe(pin_two_oe), .pin_three_out(pin_three_out),
  .pin_three_oe(pin_three_oe), .pin_five_out(pin_five_out), .pin_five_oe(pin_five_oe));
`default_nettype wire

// File: testbench/clkout_control_test.sv
// self-checking bench for the clock output pin control block
// assumes clkout_consumer on the pins and a 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module clkout_control_test;
  import clkout_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic strap = 1'b0;
  logic clear = 1'b0;
  logic [5:0] src;
  logic [15:0] rdata;
  logic [2:0] pout;
  logic [2:0] poe;
  int e2, e3, e5, fail_count = 0, comparisons = 0, cycles = 0, tick = 0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    tick <= tick + 1;
  end
  // periods in clk cycles, slow enough to survive sampling
  assign src = {tick % 16 < 8, tick % 10 < 5, tick % 8 < 4, tick % 12 < 6, tick % 14 < 7,
    tick % 6 < 3};
  clkout_control uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .second_phase_locked_loop(src[0]),
    .third_phase_locked_loop(src[1]), .fll_clock(src[2]), .osc_clock(src[3]),
    .general_io_function_two(src[4]), .general_io_function_three(src[5]),
    .strap_input(strap), .pin_two_out(pout[2]), .pin_two_oe(poe[2]),
    .pin_three_out(pout[1]), .pin_three_oe(poe[1]), .pin_five_out(pout[0]),
    .pin_five_oe(poe[0]));
  clkout_consumer board (.pin_out(pout), .pin_oe(poe), .count_clear(clear),
    .edge_two(e2), .edge_three(e3), .edge_five(e5));
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask
  // edge counts drift by one with the sampling phase
  task automatic check_count(input int got, input int exp);
    comparisons++;
    if (got < exp - 1 || got > exp + 1) begin
      fail_count++;
      $display("unexpected at %0t: %0d edges, wanted %0d", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic window;
    repeat (6) @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (240) @(posedge clk);
    #1;
  endtask
  task automatic set_strap(input logic v);
    @(posedge clk);
    strap <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_reset;
    rd_chk(8'h7c, 16'h0011);
    rd_chk(8'h7d, 16'h0003);
    rd_chk(8'h7e, 16'h000d);
    rd_chk(8'h7f, 16'h0000);
    rd_chk(8'h80, 16'h0000);
  endtask
  task automatic t_locked;
    reg_wr(8'h7c, 16'h0000);
    reg_wr(8'h7d, 16'h0000);
    rd_chk(8'h7c, 16'h0011);
    rd_chk(8'h7d, 16'h0003);
    reg_wr(8'h7c, 16'h0020);
    rd_chk(8'h7c, 16'h0031);
    reg_wr(8'h7d, 16'h0004);
    rd_chk(8'h7d, 16'h0007);
  endtask
  task automatic t_strap;
    set_strap(1'b1);
    rd_chk(8'h7c, 16'h0030);
    reg_wr(8'h7c, 16'h0021);
    rd_chk(8'h7c, 16'h0031);
    reg_wr(8'h7c, 16'h0020);
    rd_chk(8'h7c, 16'h0030);
    set_strap(1'b0);
    reg_wr(8'h7c, 16'h0020);
    rd_chk(8'h7c, 16'h0031);
  endtask
  task automatic t_override;
    reg_wr(8'h7f, 16'h0001);
    rd_chk(8'h7c, 16'h0020);
    rd_chk(8'h7d, 16'h0004);
    reg_wr(8'h7c, 16'h0049);
    rd_chk(8'h7c, 16'h0049);
    reg_wr(8'h7d, 16'h0003);
    rd_chk(8'h7d, 16'h0003);
    set_strap(1'b1);
    set_strap(1'b0);
    rd_chk(8'h7c, 16'h0049);
    reg_wr(8'h7f, 16'h0000);
    rd_chk(8'h7c, 16'h0051);
    rd_chk(8'h7d, 16'h0003);
  endtask
  task automatic t_pins;
    int exp [4] = '{40, 24, 30, 0};
    reg_wr(8'h7f, 16'h0001);
    reg_wr(8'h7d, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      reg_wr(8'h7c, 16'(c) << 5);
      window();
      check_count(e2, exp[c]);
    end
    check_count(e3, 17);
    check_count(e5, 30);
    reg_wr(8'h7c, 16'h0040);
    reg_wr(8'h7d, 16'h0006);
    window();
    check_count(e2, 15);
    check_count(e3, 9);
    reg_wr(8'h7e, 16'h0000);
    window();
    check_count(e2 + e3 + e5, 0);
    check({10'h0, poe, pout}, 16'h0);
    reg_wr(8'h7e, 16'h000d);
    window();
    check_count(e5, 30);
    reg_wr(8'h7f, 16'h0000);
    window();
    check_count(e2, 15);
    check_count(e3, 10);
    check_count(e5, 10);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_locked();
    t_strap();
    t_override();
    t_pins();
    end_sim();
  end
endmodule
`default_nettype wire

// File: verilog/clkout_control.sv
// register core and three clock output pins
// assumes source clocks and strap arrive asynchronously to clk
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - pin two takes the second loop for 00, general io two for 01, oscillator for 10.
// - with override clear, pin three select is held at 10 and writes are ignored.
// - with override set, pin three select defaults to 00 and is writable.
// - with override clear and strap low, pin five select is forced to 1 and locked.
// - with override clear, a rising strap edge loads 0 into pin five select, then writable.
// - with override set, pin five select defaults to 0 and is writable whatever the strap.
// - each enable drives the pin at 1 and tri-states it at 0; all reset to 1.
// - a halve bit of 1 divides the chosen clock by two; pin three halve resets to 0.
// - with override clear, pin two halve is forced to 1 and writes are ignored.
// - with override set, pin two halve defaults to 0 and is writable.
// - with override clear, pin five halve is forced to 1 and writes are ignored.
// - with override set, pin five halve defaults to 0 and is writable.
module clkout_control
  import clkout_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // clock sources and strap
  input wire logic second_phase_locked_loop,
  input wire logic third_phase_locked_loop,
  input wire logic fll_clock,
  input wire logic osc_clock,
  input wire logic general_io_function_two,
  input wire logic general_io_function_three,
  input wire logic strap_input,
  // pins
  output logic pin_two_out,
  output logic pin_two_oe,
  output logic pin_three_out,
  output logic pin_three_oe,
  output logic pin_five_out,
  output logic pin_five_oe
);
  // two-flop synchronisers for every asynchronous input
  logic [6:0] async_in;
  logic [6:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
  logic strap_d_r, strap_d_nxt;
  logic s_second_phase_locked_loop, s_third_phase_locked_loop, s_fll, s_osc, s_gp2, s_gp3, s_strap;

  assign async_in = {strap_input, general_io_function_three, general_io_function_two,
                     osc_clock, fll_clock, third_phase_locked_loop, second_phase_locked_loop};
  assign s_second_phase_locked_loop = sync2_r[0];
  assign s_third_phase_locked_loop = sync2_r[1];
  assign s_fll = sync2_r[2];
  assign s_osc = sync2_r[3];
  assign s_gp2 = sync2_r[4];
  assign s_gp3 = sync2_r[5];
  assign s_strap = sync2_r[6];

  // the first flop feeds only the second; nothing else may read it
  always_comb begin
    sync1_nxt = async_in;
    sync2_nxt = sync1_r;
    strap_d_nxt = s_strap;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
      strap_d_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      strap_d_r <= strap_d_nxt;
    end
  end

  // stored fields
  logic [1:0] pin_two_source_select_r, pin_two_source_select_nxt;
  logic [1:0] pin_three_source_select_r, pin_three_source_select_nxt;
  logic pin_five_source_select_r, pin_five_source_select_nxt;
  logic pin_two_halve_r, pin_two_halve_nxt;
  logic pin_three_halve_r, pin_three_halve_nxt;
  logic pin_five_halve_r, pin_five_halve_nxt;
  logic pin_two_drive_enable_r, pin_two_drive_enable_nxt;
  logic pin_three_drive_enable_r, pin_three_drive_enable_nxt;
  logic pin_five_drive_enable_r, pin_five_drive_enable_nxt;
  logic clock_register_override_r, clock_register_override_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  // effective values seen by pins and reads
  logic [1:0] eff_three_sel;
  logic eff_five_sel;
  logic eff_two_halve;
  logic eff_five_halve;
  logic five_locked;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] offset);
    return a == offset;
  endfunction

  always_comb begin
    five_locked = !clock_register_override_r && !s_strap;
    eff_three_sel = clock_register_override_r ? pin_three_source_select_r
                                              : three_sel_fll;
    eff_five_sel = five_locked ? five_sel_fll : pin_five_source_select_r;
    eff_two_halve = clock_register_override_r ? pin_two_halve_r : 1'b1;
    eff_five_halve = clock_register_override_r ? pin_five_halve_r : 1'b1;
  end

  always_comb begin
    pin_two_source_select_nxt = pin_two_source_select_r;
    pin_three_source_select_nxt = pin_three_source_select_r;
    pin_five_source_select_nxt = pin_five_source_select_r;
    pin_two_halve_nxt = pin_two_halve_r;
    pin_three_halve_nxt = pin_three_halve_r;
    pin_five_halve_nxt = pin_five_halve_r;

    if (wr && hit(addr, source_select_offset)) begin
      pin_two_source_select_nxt = wdata[pin_two_sel_lsb +: 2];
      if (clock_register_override_r) begin
        pin_three_source_select_nxt = wdata[pin_three_sel_lsb +: 2];
      end
      if (!five_locked) begin
        pin_five_source_select_nxt = wdata[pin_five_sel_bit];
      end
    end
    if (wr && hit(addr, divide_control_offset)) begin
      pin_three_halve_nxt = wdata[pin_three_halve_bit];
      if (clock_register_override_r) begin
        pin_two_halve_nxt = wdata[pin_two_halve_bit];
        pin_five_halve_nxt = wdata[pin_five_halve_bit];
      end
    end

    // strap rising edge while not overridden reloads the oscillator default
    if (!clock_register_override_r && s_strap && !strap_d_r) begin
      pin_five_source_select_nxt = five_sel_osc;
    end
    if (five_locked) begin
      pin_five_source_select_nxt = five_sel_fll;
    end

    // override change loads the defaults of the new state
    if (clock_register_override_nxt != clock_register_override_r) begin
      if (clock_register_override_nxt) begin
        pin_three_source_select_nxt = three_sel_pll;
        pin_five_source_select_nxt = five_sel_osc;
        pin_two_halve_nxt = 1'b0;
        pin_five_halve_nxt = 1'b0;
      end else begin
        pin_three_source_select_nxt = three_sel_fll;
        pin_two_halve_nxt = 1'b1;
        pin_five_halve_nxt = 1'b1;
        pin_five_source_select_nxt = s_strap ? five_sel_osc : five_sel_fll;
      end
    end
  end

  // locks act on the stored value too, yet an unlock loads the defaults, not the forced values
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_two_source_select_r <= two_sel_reset;
      pin_three_source_select_r <= three_sel_reset;
      pin_five_source_select_r <= five_sel_reset;
      pin_two_halve_r <= two_halve_reset;
      pin_three_halve_r <= three_halve_reset;
      pin_five_halve_r <= five_halve_reset;
    end else begin
      pin_two_source_select_r <= pin_two_source_select_nxt;
      pin_three_source_select_r <= pin_three_source_select_nxt;
      pin_five_source_select_r <= pin_five_source_select_nxt;
      pin_two_halve_r <= pin_two_halve_nxt;
      pin_three_halve_r <= pin_three_halve_nxt;
      pin_five_halve_r <= pin_five_halve_nxt;
    end
  end

  // read data stands for one cycle after the strobe and is zero otherwise
  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd) begin
      case (addr)
        source_select_offset: begin
          rdata_nxt[pin_two_sel_lsb +: 2] = pin_two_source_select_r;
          rdata_nxt[pin_three_sel_lsb +: 2] = eff_three_sel;
          rdata_nxt[pin_five_sel_bit] = eff_five_sel;
        end
        divide_control_offset: begin
          rdata_nxt[pin_three_halve_bit] = pin_three_halve_r;
          rdata_nxt[pin_two_halve_bit] = eff_two_halve;
          rdata_nxt[pin_five_halve_bit] = eff_five_halve;
        end
        pin_enable_offset: begin
          rdata_nxt[pin_two_enable_bit] = pin_two_drive_enable_r;
          rdata_nxt[pin_three_enable_bit] = pin_three_drive_enable_r;
          rdata_nxt[pin_five_enable_bit] = pin_five_drive_enable_r;
        end
        override_offset: begin
          rdata_nxt[override_bit] = clock_register_override_r;
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // override bit; the field group sees its change as an event
  always_comb begin
    clock_register_override_nxt = clock_register_override_r;
    if (wr && hit(addr, override_offset)) begin
      clock_register_override_nxt = wdata[override_bit];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clock_register_override_r <= override_reset;
    end else begin
      clock_register_override_r <= clock_register_override_nxt;
    end
  end

  // drive enables are never locked and have no override default
  always_comb begin
    pin_two_drive_enable_nxt = pin_two_drive_enable_r;
    pin_three_drive_enable_nxt = pin_three_drive_enable_r;
    pin_five_drive_enable_nxt = pin_five_drive_enable_r;
    if (wr && hit(addr, pin_enable_offset)) begin
      pin_two_drive_enable_nxt = wdata[pin_two_enable_bit];
      pin_three_drive_enable_nxt = wdata[pin_three_enable_bit];
      pin_five_drive_enable_nxt = wdata[pin_five_enable_bit];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_two_drive_enable_r <= enable_reset;
      pin_three_drive_enable_r <= enable_reset;
      pin_five_drive_enable_r <= enable_reset;
    end else begin
      pin_two_drive_enable_r <= pin_two_drive_enable_nxt;
      pin_three_drive_enable_r <= pin_three_drive_enable_nxt;
      pin_five_drive_enable_r <= pin_five_drive_enable_nxt;
    end
  end

  assign rdata = rdata_r;

  // sources are sampled on clk, so they must run well below half its rate
  // pin stages; reserved code 11 picks a quiet low source
  clkout_pin_if two_if();
  clkout_pin_if three_if();
  clkout_pin_if five_if();

  assign two_if.sources = {1'b0, s_osc, s_gp2, s_second_phase_locked_loop};
  assign two_if.select = pin_two_source_select_r;
  assign two_if.halve = eff_two_halve;
  assign two_if.enable = pin_two_drive_enable_r;
  assign three_if.sources = {1'b0, s_fll, s_gp3, s_third_phase_locked_loop};
  assign three_if.select = eff_three_sel;
  assign three_if.halve = pin_three_halve_r;
  assign three_if.enable = pin_three_drive_enable_r;
  assign five_if.sources = {2'b00, s_fll, s_osc};
  assign five_if.select = {1'b0, eff_five_sel};
  assign five_if.halve = eff_five_halve;
  assign five_if.enable = pin_five_drive_enable_r;

  clkout_pin_stage two_stage (
    .clk(clk),
    .resetn(resetn),
    .ctl(two_if.pin),
    .pin_out(pin_two_out),
    .pin_oe(pin_two_oe)
  );
  clkout_pin_stage three_stage (
    .clk(clk),
    .resetn(resetn),
    .ctl(three_if.pin),
    .pin_out(pin_three_out),
    .pin_oe(pin_three_oe)
  );
  clkout_pin_stage five_stage (
    .clk(clk),
    .resetn(resetn),
    .ctl(five_if.pin),
    .pin_out(pin_five_out),
    .pin_oe(pin_five_oe)
  );
endmodule
`default_nettype wire

// File: verilog/clkout_pin_if.sv
// bundle between the register core and one output pin stage
// assumes source clocks are sampled in the clk domain
`timescale 1ns/1ps
`default_nettype none
interface clkout_pin_if;
  logic [3:0] sources;
  logic [1:0] select;
  logic halve;
  logic enable;
  modport ctrl (output sources, output select, output halve, output enable);
  modport pin (input sources, input select, input halve, input enable);
endinterface
`default_nettype wire

// File: verilog/clkout_pin_stage.sv
// one output pin: source mux, optional halving, drive enable
// assumes sources already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module clkout_pin_stage
  import clkout_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  clkout_pin_if.pin ctl,
  // pin
  output logic pin_out,
  output logic pin_oe
);
  logic picked;
  logic picked_d_r, picked_d_nxt;
  logic half_r, half_nxt;
  logic out_r, out_nxt;
  logic oe_r, oe_nxt;

  always_comb begin
    picked = ctl.sources[ctl.select];
    picked_d_nxt = picked;
    half_nxt = half_r;
    // toggle on each rising edge of the chosen source
    if (picked && !picked_d_r) begin
      half_nxt = ~half_r;
    end
    out_nxt = ctl.halve ? half_r : picked;
    oe_nxt = ctl.enable;
    if (!ctl.enable) begin
      out_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      picked_d_r <= 1'b0;
      half_r <= 1'b0;
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      picked_d_r <= picked_d_nxt;
      half_r <= half_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign pin_out = out_r;
  assign pin_oe = oe_r;
endmodule
`default_nettype wire

// File: verilog/clkout_pkg.sv
// constants for the clock output pin control block
// assumes a single 20 MHz clock domain and a plain register port
package clkout_pkg;
  localparam logic [7:0] source_select_offset = 8'h7c;
  localparam logic [7:0] divide_control_offset = 8'h7d;
  localparam logic [7:0] pin_enable_offset = 8'h7e;
  localparam logic [7:0] override_offset = 8'h7f;
  // field positions
  localparam int pin_two_sel_lsb = 5;
  localparam int pin_three_sel_lsb = 3;
  localparam int pin_five_sel_bit = 0;
  localparam int pin_three_halve_bit = 2;
  localparam int pin_two_halve_bit = 1;
  localparam int pin_five_halve_bit = 0;
  localparam int pin_two_enable_bit = 3;
  localparam int pin_three_enable_bit = 2;
  localparam int pin_five_enable_bit = 0;
  localparam int override_bit = 0;
  // source codes
  localparam logic [1:0] two_sel_pll = 2'h0;
  localparam logic [1:0] two_sel_gpio = 2'h1;
  localparam logic [1:0] two_sel_osc = 2'h2;
  localparam logic [1:0] three_sel_pll = 2'h0;
  localparam logic [1:0] three_sel_gpio = 2'h1;
  localparam logic [1:0] three_sel_fll = 2'h2;
  localparam logic five_sel_osc = 1'h0;
  localparam logic five_sel_fll = 1'h1;
  // reset values
  localparam logic [1:0] two_sel_reset = 2'h0;
  localparam logic [1:0] three_sel_reset = 2'h2;
  localparam logic five_sel_reset = 1'h1;
  localparam logic two_halve_reset = 1'h1;
  localparam logic three_halve_reset = 1'h0;
  localparam logic five_halve_reset = 1'h1;
  localparam logic enable_reset = 1'h1;
  localparam logic override_reset = 1'h0;
endpackage
